// File: core/eia_pkg.sv
// Constants, register map and state type of the nonvolatile indirect access block
package eia_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] NVM_WORD_INDEX_OFS = 8'h40;
	localparam logic [7:0] NVM_DATA_LOW_OFS = 8'h42;
	localparam logic [7:0] NVM_DATA_HIGH_OFS = 8'h43;
	localparam logic [7:0] NVM_OPERATION_CONTROL_OFS = 8'h44;
	localparam logic [7:0] NVM_ENABLE_CONTROL_OFS = 8'h45;
	localparam logic [7:0] NVM_PULSE_CONTROL_OFS = 8'h46;
	localparam logic [7:0] FN_SPAN = 8'h40;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int ACTIVITY_BIT = 7;
	localparam int BLOCK_ERASE_BIT = 6;
	localparam int ADDRESS_ERASE_BIT = 5;
	localparam int BLOCK_WRITE_BIT = 4;
	localparam int BATCH_WRITE_BIT = 3;
	localparam int SINGLE_WRITE_BIT = 2;
	localparam int BATCH_READ_BIT = 1;
	localparam int SINGLE_READ_BIT = 0;
	localparam logic [6:0] REQUEST_MASK = 7'h7F;
	localparam int ENABLED_STATUS_BIT = 7;
	localparam int PUMP_STATUS_BIT = 6;
	localparam int DISABLE_BIT = 1;
	localparam int ENABLE_BIT = 0;
	localparam int PULSE_BIT = 0;
	localparam logic [7:0] PULSE_KEEP_MASK = 8'hE1;
	// ----------------------------------------
	// Timing and sizes
	// ----------------------------------------
	localparam logic [8:0] WAIT_CYCLES = 9'h00A;
	localparam logic [9:0] LOAD_CYCLES = 10'h200;
	localparam logic [3:0] LOAD_PHASE = 4'h0;
	localparam logic [8:0] READ_CYCLES = 9'h004;
	localparam logic [8:0] FN_WORDS = 9'h020;
	localparam logic [8:0] NVM_WORDS = 9'h100;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;

	typedef enum logic [2:0] {
		EIA_ST_WAIT,
		EIA_ST_LOAD,
		EIA_ST_IDLE,
		EIA_ST_READ,
		EIA_ST_PULSE_HI,
		EIA_ST_PULSE_LO,
		EIA_ST_SWEEP
	} eia_state_t;
endpackage

// File: core/eia_core.sv
// Register-indirect access controller for the on-chip nonvolatile word array
// Summary of operation
// [R01] After reset the array contents are copied into the function registers unprompted.
// [R02] Host reaches the array only through index, data and control registers.
// [R03] Word index register at 40h, eight bits, read/write, resets to 00h.
// [R04] Sixteen-bit word: low byte at 42h, high byte at 43h, both directions.
// [R05] Bit 7 at 44h reads 1 while an operation runs, else 0.
// [R06] Bits 6..0 at 44h request the seven array operations.
// [R07] Several requests at once: only the highest priority one executes.
// [R08] Block erase request bit reads 1 while the block erase runs.
// [R09] Address erase clears only the word selected by the index register.
// [R10] Host sets enable before array operations and disable afterwards.
// [R11] Host holds the pulse bit high 4 to 8 ms, then clears it; the test host holds it only about 2 us.
// [R12] Single read request bit stays 1 during transfer, clears when done.
// [R13] Wait 10 cycles after reset, then the power-on array read takes 512.
// [R14] Activity flag rises on acceptance, falls when the whole operation ends.
module eia_core
	import eia_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output logic array_activity_flag_o
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [15:0] nvm_mem [256];
	logic [7:0] fn_reg [64];

	eia_state_t state_reg, state_next;
	logic [8:0] cnt_reg, cnt_next;
	logic [7:0] nvm_word_index_reg, nvm_word_index_next;
	logic [15:0] data_reg, data_next;
	logic [6:0] op_reg, op_next;
	logic busy_reg, busy_next;
	logic enabled_reg, enabled_next;
	logic [7:0] pulse_reg, pulse_next;
	logic [7:0] rdata_reg, rdata_next;

	logic mem_we;
	logic [7:0] mem_addr;
	logic [15:0] mem_wdata;
	logic load_we;
	logic host_fn_we;
	logic abort;
	logic done;
	logic [7:0] rd_val;
	logic [4:0] fn_word;

	// Lowest set bit wins, so a single read outranks every other request
	function automatic logic [6:0] pick_op(input logic [6:0] req);
		pick_op = req & (~req + 7'h01);
	endfunction

	// Host write and read at a given offset
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	assign fn_word = cnt_reg[8:4];

	// ----------------------------------------
	// Register read mux
	// ----------------------------------------
	always_comb begin
		rd_val = RESET_BYTE;
		if (reg_addr_i < FN_SPAN) begin
			rd_val = fn_reg[reg_addr_i[5:0]];
		end else if (hit(reg_addr_i, NVM_WORD_INDEX_OFS)) begin
			rd_val = nvm_word_index_reg; // [R03]
		end else if (hit(reg_addr_i, NVM_DATA_LOW_OFS)) begin
			rd_val = data_reg[7:0]; // [R04]
		end else if (hit(reg_addr_i, NVM_DATA_HIGH_OFS)) begin
			rd_val = data_reg[15:8]; // [R04]
		end else if (hit(reg_addr_i, NVM_OPERATION_CONTROL_OFS)) begin
			rd_val = {busy_reg, op_reg}; // [R05] [R08] [R12]
		end else if (hit(reg_addr_i, NVM_ENABLE_CONTROL_OFS)) begin
			rd_val[ENABLED_STATUS_BIT] = enabled_reg;
			rd_val[PUMP_STATUS_BIT] = (state_reg == EIA_ST_PULSE_LO) && pulse_reg[PULSE_BIT];
		end else if (hit(reg_addr_i, NVM_PULSE_CONTROL_OFS)) begin
			rd_val = pulse_reg;
		end
	end

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		nvm_word_index_next = nvm_word_index_reg;
		data_next = data_reg;
		op_next = op_reg;
		busy_next = busy_reg;
		enabled_next = enabled_reg;
		pulse_next = pulse_reg;
		rdata_next = reg_rd_i ? rd_val : rdata_reg;
		mem_we = 1'b0;
		mem_addr = nvm_word_index_reg;
		mem_wdata = data_reg;
		load_we = 1'b0;
		host_fn_we = 1'b0;
		done = 1'b0;
		abort = reg_wr_i && hit(reg_addr_i, NVM_OPERATION_CONTROL_OFS) && (reg_wdata_i == RESET_BYTE);

		// Host writes; apart from the power-on load the array is only reached through these
		if (reg_wr_i) begin // [R02]
			if (reg_addr_i < FN_SPAN) begin
				host_fn_we = 1'b1;
			end else if (hit(reg_addr_i, NVM_WORD_INDEX_OFS)) begin
				nvm_word_index_next = reg_wdata_i; // [R03]
			end else if (hit(reg_addr_i, NVM_DATA_LOW_OFS)) begin
				data_next[7:0] = reg_wdata_i; // [R04]
			end else if (hit(reg_addr_i, NVM_DATA_HIGH_OFS)) begin
				data_next[15:8] = reg_wdata_i; // [R04]
			end else if (hit(reg_addr_i, NVM_ENABLE_CONTROL_OFS)) begin
				// Disable wins if both bits come together
				if (reg_wdata_i[ENABLE_BIT]) begin
					enabled_next = 1'b1;
				end
				if (reg_wdata_i[DISABLE_BIT]) begin
					enabled_next = 1'b0;
				end
			end else if (hit(reg_addr_i, NVM_PULSE_CONTROL_OFS)) begin
				pulse_next = reg_wdata_i & PULSE_KEEP_MASK;
			end else if (hit(reg_addr_i, NVM_OPERATION_CONTROL_OFS)) begin
				// Requests are ignored while busy or before the host enables access
				if (state_reg == EIA_ST_IDLE && enabled_reg &&
					(reg_wdata_i[6:0] & REQUEST_MASK) != 7'h00) begin // [R10]
					op_next = pick_op(reg_wdata_i[6:0]); // [R06] [R07]
					busy_next = 1'b1; // [R14]
					cnt_next = '0;
					if (op_next[SINGLE_READ_BIT]) begin
						state_next = EIA_ST_READ;
					end else if (op_next[BATCH_READ_BIT]) begin
						state_next = EIA_ST_LOAD;
					end else begin
						state_next = EIA_ST_PULSE_HI;
					end
				end
			end
		end

		unique case (state_reg)
			EIA_ST_WAIT: begin
				cnt_next = cnt_reg + 9'h001;
				if (cnt_reg == WAIT_CYCLES - 9'h001) begin // [R13]
					state_next = EIA_ST_LOAD; // [R01]
					cnt_next = '0;
					busy_next = 1'b1;
				end
			end
			EIA_ST_LOAD: begin
				// One word every sixteen cycles fills the span in exactly 512
				load_we = (cnt_reg[3:0] == LOAD_PHASE); // [R01]
				cnt_next = cnt_reg + 9'h001;
				if ({1'b0, cnt_reg} == LOAD_CYCLES - 10'h001) begin // [R13]
					done = 1'b1;
				end
			end
			EIA_ST_IDLE: begin
			end
			EIA_ST_READ: begin
				cnt_next = cnt_reg + 9'h001;
				if (cnt_reg == READ_CYCLES - 9'h001) begin
					data_next = nvm_mem[nvm_word_index_reg]; // [R12]
					done = 1'b1;
				end
			end
			EIA_ST_PULSE_HI: begin
				if (abort) begin
					done = 1'b1;
				end else if (pulse_reg[PULSE_BIT]) begin // [R11]
					state_next = EIA_ST_PULSE_LO;
				end
			end
			EIA_ST_PULSE_LO: begin
				// Programming takes effect when the host ends the pulse
				if (abort) begin
					done = 1'b1;
				end else if (!pulse_reg[PULSE_BIT]) begin // [R11]
					if (op_reg[SINGLE_WRITE_BIT]) begin
						mem_we = 1'b1;
						done = 1'b1;
					end else if (op_reg[ADDRESS_ERASE_BIT]) begin
						mem_we = 1'b1; // [R09]
						mem_wdata = ERASED_WORD;
						done = 1'b1;
					end else if (op_reg[BATCH_WRITE_BIT]) begin
						mem_we = 1'b1;
						mem_addr = cnt_reg[7:0];
						mem_wdata = {fn_reg[{cnt_reg[4:0], 1'b1}], fn_reg[{cnt_reg[4:0], 1'b0}]};
						cnt_next = cnt_reg + 9'h001;
						if (cnt_reg == FN_WORDS - 9'h001) begin
							done = 1'b1;
						end else begin
							state_next = EIA_ST_PULSE_HI;
						end
					end else begin
						state_next = EIA_ST_SWEEP;
						cnt_next = '0;
					end
				end
			end
			EIA_ST_SWEEP: begin
				// Block operations walk the array one word per cycle
				mem_we = 1'b1;
				mem_addr = cnt_reg[7:0];
				mem_wdata = op_reg[BLOCK_WRITE_BIT] ? data_reg : ERASED_WORD; // [R08]
				cnt_next = cnt_reg + 9'h001;
				if (cnt_reg == NVM_WORDS - 9'h001) begin
					done = 1'b1;
				end
			end
		endcase

		if (done) begin
			state_next = EIA_ST_IDLE;
			op_next = '0; // [R12] [R08]
			busy_next = 1'b0; // [R05] [R14]
			cnt_next = '0;
		end
	end

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			state_reg <= EIA_ST_WAIT;
			cnt_reg <= '0;
			nvm_word_index_reg <= RESET_BYTE;
			data_reg <= {RESET_BYTE, RESET_BYTE};
			op_reg <= '0;
			busy_reg <= 1'b0;
			enabled_reg <= 1'b0;
			pulse_reg <= RESET_BYTE;
			rdata_reg <= RESET_BYTE;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			nvm_word_index_reg <= nvm_word_index_next;
			data_reg <= data_next;
			op_reg <= op_next;
			busy_reg <= busy_next;
			enabled_reg <= enabled_next;
			pulse_reg <= pulse_next;
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------
	// Array and function registers
	// ----------------------------------------
	// The array has no reset: its contents are meant to survive power cycles
	always_ff @(posedge sys_clk_i) begin
		if (mem_we) begin
			nvm_mem[mem_addr] <= mem_wdata;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			for (int i = 0; i < 64; i++) begin
				fn_reg[i] <= RESET_BYTE;
			end
		end else if (load_we) begin
			fn_reg[{fn_word, 1'b0}] <= nvm_mem[{3'h0, fn_word}][7:0]; // [R01]
			fn_reg[{fn_word, 1'b1}] <= nvm_mem[{3'h0, fn_word}][15:8];
		end else if (host_fn_we) begin
			fn_reg[reg_addr_i[5:0]] <= reg_wdata_i;
		end
	end

	assign reg_rdata_o = rdata_reg;
	assign array_activity_flag_o = busy_reg;
endmodule // eia_core

// File: verification/eia_chk.sv
// Concurrent checks on the register port of the array access block
module eia_chk (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic array_activity_flag_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Cycles since reset, saturating so it never wraps back into the load window
	// ----
	logic [9:0] since_reg;
	always_ff @(posedge sys_clk_i) begin
		since_reg <= reset_i ? 10'h000 : since_reg + {9'h000, since_reg != 10'h3FF};
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	a_reset_clears: assert property (disable iff (1'b0) reset_i |=>
		!array_activity_flag_o && reg_rdata_o == 8'h00) else $error("outputs not cleared");
	a_wait_before_load: assert property (since_reg < 10'h008 |-> !array_activity_flag_o)
		else $error("busy during wait");
	a_load_running: assert property ((since_reg >= 10'h00E && since_reg <= 10'h203)
		|-> array_activity_flag_o) else $error("power-on load not busy");
	a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved without read");
	a_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 8'h41 |=>
		reg_rdata_o == 8'h00) else $error("unmapped read not zero");
	a_flag_in_status: assert property (reg_rd_i && reg_addr_i == 8'h44 |=>
		reg_rdata_o[7] == $past(array_activity_flag_o)) else $error("status bit differs");
	a_busy_min_span: assert property ($rose(array_activity_flag_o) |->
		array_activity_flag_o[*4]) else $error("operation too short");
	a_start_on_write: assert property ($rose(array_activity_flag_o) && since_reg > 10'h010
		|-> $past(reg_wr_i) && $past(reg_addr_i) == 8'h44) else $error("busy without request");
endmodule // eia_chk

bind eia_core eia_chk eia_chk_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.array_activity_flag_o(array_activity_flag_o));

// File: verification/eia_host.sv
// Host processor model driving the register port
module eia_host #(
	parameter int PULSE_CYCLES = 40
) (
	input wire logic sys_clk_i,
	input wire logic [7:0] rdata_i,
	output logic [7:0] addr_o = 8'h00,
	output logic [7:0] wdata_o = 8'h00,
	output logic wr_o = 1'b0,
	output logic rd_o = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	// Released lines flip so a stale value never looks valid
	task automatic release_bus();
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = ~addr_o;
		wdata_o = ~wdata_o;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge sys_clk_i);
		release_bus();
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge sys_clk_i);
		d = rdata_i;
		release_bus();
	endtask
	task automatic start_op(input logic [7:0] req);
		wr_reg(8'h45, 8'h01);
		wr_reg(8'h44, req);
	endtask
	// Device does not time the pulse, so it is far below 4 ms to keep runs short
	task automatic pulse();
		wr_reg(8'h46, 8'h01);
		repeat (PULSE_CYCLES) @(negedge sys_clk_i);
		wr_reg(8'h46, 8'h00);
	endtask
endmodule // eia_host

// File: verification/test_eia_core.sv
// Self-checking testbench of the array access block
module test_eia_core;
	timeunit 1ns;
	timeprecision 1ns;
	`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin bad_count++; \
		$display("wrong value %s expected %h seen %h", nm, ex, got); end end
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rd_val;
	logic reg_wr_i, reg_rd_i, array_activity_flag_o;
	int bad_count = 0;
	int compares = 0;
	int n;
	always #25 sys_clk_i = ~sys_clk_i;
	eia_core eia_core_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .array_activity_flag_o(array_activity_flag_o));
	eia_host eia_host_i (.sys_clk_i(sys_clk_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
		.wdata_o(reg_wdata_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i));
	// ----
	// Shared steps
	// ----
	task automatic expect_reg(input logic [7:0] a, input logic [7:0] ex, input string nm);
		eia_host_i.rd_reg(a, rd_val);
		`CHK(nm, ex, rd_val)
	endtask
	task automatic count_while(input logic level);
		n = 0;
		while (array_activity_flag_o === level && n < 2000) begin
			@(negedge sys_clk_i);
			n++;
		end
	endtask
	task automatic do_reset();
		reset_i = 1'b1;
		repeat (5) @(negedge sys_clk_i);
		reset_i = 1'b0;
		count_while(1'b0);
		`CHK("wait span", 10, n)
		count_while(1'b1);
		`CHK("load span", 512, n)
	endtask
	task automatic wait_done();
		count_while(1'b1);
		eia_host_i.wr_reg(8'h45, 8'h02);
		`CHK("busy after op", 1'b0, array_activity_flag_o)
	endtask
	task automatic write_word(input logic [7:0] idx, input logic [15:0] w);
		eia_host_i.wr_reg(8'h40, idx);
		eia_host_i.wr_reg(8'h42, w[7:0]);
		eia_host_i.wr_reg(8'h43, w[15:8]);
		eia_host_i.start_op(8'h04);
		eia_host_i.pulse();
		wait_done();
	endtask
	task automatic read_word(input logic [7:0] idx, input logic [15:0] w);
		eia_host_i.wr_reg(8'h40, idx);
		eia_host_i.start_op(8'h01);
		expect_reg(8'h44, 8'h81, "read status");
		wait_done();
		expect_reg(8'h44, 8'h00, "read cleared");
		expect_reg(8'h42, w[7:0], "low byte");
		expect_reg(8'h43, w[15:8], "high byte");
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_power_on();
		do_reset();
		expect_reg(8'h40, 8'h00, "index reset");
		expect_reg(8'h42, 8'h00, "low reset");
		expect_reg(8'h43, 8'h00, "high reset");
		expect_reg(8'h41, 8'h00, "unmapped");
		expect_reg(8'h45, 8'h00, "enable reset");
		expect_reg(8'h46, 8'h00, "pulse reset");
	endtask
	task automatic t_words_and_priority();
		write_word(8'h00, 16'hA5C3);
		write_word(8'h01, 16'h0F1E);
		write_word(8'hFF, 16'h5AA5);
		read_word(8'h00, 16'hA5C3);
		eia_host_i.wr_reg(8'h40, 8'h01);
		eia_host_i.start_op(8'h05);
		count_while(1'b1);
		`CHK("read wins", 1'b1, n <= 6)
		expect_reg(8'h42, 8'h1E, "winner data");
	endtask
	task automatic t_reload();
		do_reset();
		expect_reg(8'h00, 8'hC3, "fn 00");
		expect_reg(8'h01, 8'hA5, "fn 01");
		expect_reg(8'h02, 8'h1E, "fn 02");
	endtask
	task automatic t_erase();
		eia_host_i.wr_reg(8'h40, 8'h01);
		eia_host_i.start_op(8'h20);
		eia_host_i.pulse();
		wait_done();
		read_word(8'h01, 16'hFFFF);
		read_word(8'h00, 16'hA5C3);
		eia_host_i.start_op(8'h40);
		expect_reg(8'h44, 8'hC0, "block erase status");
		eia_host_i.wr_reg(8'h46, 8'h01);
		expect_reg(8'h45, 8'hC0, "pump status");
		expect_reg(8'h46, 8'h01, "pulse readback");
		eia_host_i.pulse();
		wait_done();
		read_word(8'hFF, 16'hFFFF);
	endtask
	task automatic t_batch_and_block();
		eia_host_i.wr_reg(8'h3E, 8'h34);
		eia_host_i.wr_reg(8'h3F, 8'h12);
		eia_host_i.start_op(8'h08);
		repeat (31) eia_host_i.pulse();
		repeat (2) @(negedge sys_clk_i);
		`CHK("batch busy", 1'b1, array_activity_flag_o)
		eia_host_i.pulse();
		wait_done();
		read_word(8'h1F, 16'h1234);
		eia_host_i.wr_reg(8'h3E, 8'h00);
		eia_host_i.start_op(8'h02);
		expect_reg(8'h44, 8'h82, "batch read status");
		wait_done();
		expect_reg(8'h3E, 8'h34, "fn 3E");
		expect_reg(8'h3F, 8'h12, "fn 3F");
		eia_host_i.wr_reg(8'h42, 8'hCD);
		eia_host_i.wr_reg(8'h43, 8'hAB);
		eia_host_i.start_op(8'h10);
		eia_host_i.pulse();
		wait_done();
		read_word(8'h80, 16'hABCD);
		// Abort lands while the pulse is high, so the falling pulse must not erase
		eia_host_i.start_op(8'h20);
		eia_host_i.wr_reg(8'h46, 8'h01);
		eia_host_i.wr_reg(8'h44, 8'h00);
		eia_host_i.wr_reg(8'h46, 8'h00);
		expect_reg(8'h44, 8'h00, "abort status");
		wait_done();
		read_word(8'h80, 16'hABCD);
	endtask
	task automatic end_sim();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		#1_000_000;
		bad_count++;
		end_sim();
	end
	initial begin
		t_power_on();
		t_words_and_priority();
		t_reload();
		t_erase();
		t_batch_and_block();
		end_sim();
	end
endmodule // test_eia_core
